// *** src/uif_flag_regs.sv ***
`timescale 1ns/10ps
// Contract
// - Sticky-select bit set: flag holds until software writes one to it.
// - Sticky-select clear: rx active and rx error follow their sources; other flags may be overwritten.
// - Each flag port is high when any masked flag is high.
// - Four 8-bit port masks, lowest byte first port, all reset zero.
// - 11-bit frame counter, software read/write, resets to zero.
// - Last received packet identifier captured, read-only, resets zero.
// - Last token endpoint stored read-only with a separate valid bit.
// - Marked endpoints appear on receive port ORed with 0x10.
// - Pulldown-disable bit turns off pulldowns on both PHY data ports.
// - SE0 auto-resume sets reset-cause bit until software writes zero.
// - K auto-resume sets resume-cause bit until software writes zero.
// - Linestate change propagates only after persisting 2**filter + 1 cycles.
// - Auto-resume bit hands resume to suspend controller, else software polls.
// - Three-bit field drives the PHY configuration pins directly.
// - Flags 6..0: token, SE0, K, J, CRC16 fail, rx active, rx error.
// - Non-sticky flags except rx active and rx error clear automatically when the next packet arrives.
module uif_flag_regs
  import uif_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Peripheral register port, full 32-bit words only
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // Packet events from the interface state machine
  input  wire logic        packet_start,
  input  wire logic        token_ok,
  input  wire logic        crc16_fail,
  input  wire logic        rx_active,
  input  wire logic        rx_error,
  input  wire logic        pid_valid,
  input  wire logic [3:0]  pid_in,
  input  wire logic        token_ep_valid,
  input  wire logic [3:0]  token_ep,
  input  wire logic        sof_valid,
  input  wire logic [10:0] sof_number,
  // Suspend controller events
  input  wire logic        resume_by_se0,
  input  wire logic        resume_by_k,
  // PHY linestate pins
  input  wire logic [1:0]  phy_linestate,
  // Outputs
  output logic             flag_port_a,
  output logic             flag_port_b,
  output logic             flag_port_c,
  output logic             flag_port_d,
  output logic      [4:0]  rx_port_endpoint,
  output logic      [1:0]  linestate_filt,
  output logic             auto_resume_en,
  output logic      [2:0]  phy_config_pins,
  output logic             phy_pulldown_disable,
  output logic      [31:0] otg_flag_mask,
  output logic      [8:0]  power_word
);
  // ==========================================================
  // Register state
  // Signal flags and their sticky selection
  logic [6:0]  flags_reg;
  logic [6:0]  flags_next;
  logic [6:0]  sticky_reg;
  logic [6:0]  sticky_next;
  // Port masks, frame counter and captured packet fields
  logic [31:0] masks_reg;
  logic [31:0] masks_next;
  logic [10:0] frame_reg;
  logic [10:0] frame_next;
  logic [3:0]  pid_reg;
  logic [3:0]  pid_next;
  logic [4:0]  ep_reg;
  logic [4:0]  ep_next;
  // Endpoint marking, OTG mask, power word and PHY control
  logic [15:0] mark_reg;
  logic [15:0] mark_next;
  logic [31:0] otg_reg;
  logic [31:0] otg_next;
  logic [8:0]  power_reg;
  logic [8:0]  power_next;
  logic [31:0] phy_reg;
  logic [31:0] phy_next;
  // Read data, held until the next read strobe
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // Linestate synchroniser stages
  logic [1:0]  ls_meta_reg;
  logic [1:0]  ls_sync_reg;
  // Decoded helpers
  logic [6:0]  flag_src;
  logic [6:0]  flag_w1c;
  logic [31:0] phy_wmask;
  logic [3:0]  port_any;

  // Writable bits of the PHY control word
  // Reserved bits are cleared so they always read back as zero
  assign phy_wmask = (32'h1 << UIF_PHY_PD_DIS) | (32'h1 << UIF_PHY_RST_CS) | (32'h1 << UIF_PHY_RES_CS)
                   | (32'hF << UIF_PHY_FILT_LO) | (32'h1 << UIF_PHY_AUTO) | (32'h7 << UIF_PHY_CONF_LO);

  // ==========================================================
  // Linestate synchroniser and filter
  // Two stages: only the second one feeds logic, the first may settle late
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ls_meta_reg <= UIF_LS_J;
      ls_sync_reg <= UIF_LS_J;
    end else begin
      ls_meta_reg <= phy_linestate;
      ls_sync_reg <= ls_meta_reg;
    end
  end

  // Filter length comes from the PHY control word
  uif_ls_filter u_filter (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ls_in    (ls_sync_reg),
    .log2_len (phy_reg[UIF_PHY_FILT_LO +: 4]),
    .ls_filt  (linestate_filt)
  );

  // ==========================================================
  // Flag sources, in flag bit order
  // Line flags come from the filtered linestate, so short glitches never set them
  always_comb begin
    flag_src              = '0;
    flag_src[UIF_F_TOKEN] = token_ok;
    flag_src[UIF_F_SE0]   = (linestate_filt == UIF_LS_SE0);
    flag_src[UIF_F_K]     = (linestate_filt == UIF_LS_K);
    flag_src[UIF_F_J]     = (linestate_filt == UIF_LS_J);
    flag_src[UIF_F_CRC16] = crc16_fail;
    flag_src[UIF_F_RXACT] = rx_active;
    flag_src[UIF_F_RXERR] = rx_error;
  end

  // Write-one-to-clear strobes for the flag register
  assign flag_w1c = (reg_wr && reg_addr == UIF_ADDR_FLAGS) ? reg_wdata[6:0] : 7'h0;

  // ==========================================================
  // Per-flag update: a hardware set outranks a software clear, so no event is lost
  always_comb begin
    flags_next = flags_reg;
    // Receive levels track their inputs; other plain flags wait for the next packet
    for (int i = 0; i < UIF_NFLAGS; i++) begin
      if (sticky_reg[i]) begin
        if (flag_src[i]) begin
          flags_next[i] = 1'b1;
        end else if (flag_w1c[i]) begin
          flags_next[i] = 1'b0;
        end
      end else if (i == UIF_F_RXACT || i == UIF_F_RXERR) begin
        flags_next[i] = flag_src[i];
      end else if (flag_src[i]) begin
        flags_next[i] = 1'b1;
      end else if (packet_start) begin
        flags_next[i] = 1'b0;
      end
    end
  end

  // ==========================================================
  // Software-visible registers
  always_comb begin
    sticky_next = sticky_reg;
    masks_next  = masks_reg;
    frame_next  = frame_reg;
    pid_next    = pid_reg;
    ep_next     = ep_reg;
    mark_next   = mark_reg;
    otg_next    = otg_reg;
    power_next  = power_reg;
    phy_next    = phy_reg;
    // A frame load loses to a software write in the same cycle
    if (sof_valid) begin
      frame_next = sof_number;
    end
    // Captured packet identifier and token endpoint
    if (pid_valid) begin
      pid_next = pid_in;
    end
    if (token_ep_valid) begin
      ep_next = {1'b1, token_ep};
    end
    // Whole-word writes only; read-only and unmapped offsets ignore them
    // Reserved PHY control bits are dropped by the write mask
    if (reg_wr) begin
      unique case (reg_addr)
        UIF_ADDR_STICKY:     sticky_next = reg_wdata[6:0];
        UIF_ADDR_PORT_MASKS: masks_next  = reg_wdata;
        UIF_ADDR_FRAME:      frame_next  = reg_wdata[10:0];
        UIF_ADDR_EP_MARK:    mark_next   = reg_wdata[15:0];
        UIF_ADDR_OTG_MASK:   otg_next    = reg_wdata;
        UIF_ADDR_POWER:      power_next  = reg_wdata[8:0];
        UIF_ADDR_PHY_CTRL:   phy_next    = reg_wdata & phy_wmask;
        default:             ;
      endcase
    end
    // Cause bits: hardware set wins over a software clear
    if (resume_by_se0) begin
      phy_next[UIF_PHY_RST_CS] = 1'b1;
    end
    if (resume_by_k) begin
      phy_next[UIF_PHY_RES_CS] = 1'b1;
    end
  end

  // ==========================================================
  // Read data mux, registered; unmapped offsets read as zero
  // A read and a write in one cycle return the old value
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      unique case (reg_addr)
        UIF_ADDR_FLAGS:      rdata_next = {25'h0, flags_reg};
        UIF_ADDR_STICKY:     rdata_next = {25'h0, sticky_reg};
        UIF_ADDR_PORT_MASKS: rdata_next = masks_reg;
        UIF_ADDR_FRAME:      rdata_next = {21'h0, frame_reg};
        UIF_ADDR_PID:        rdata_next = {28'h0, pid_reg};
        UIF_ADDR_ENDPOINT:   rdata_next = {27'h0, ep_reg};
        UIF_ADDR_EP_MARK:    rdata_next = {16'h0, mark_reg};
        UIF_ADDR_OTG_MASK:   rdata_next = otg_reg;
        UIF_ADDR_POWER:      rdata_next = {23'h0, power_reg};
        UIF_ADDR_PHY_CTRL:   rdata_next = phy_reg;
        default:             rdata_next = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Flag register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Software-visible register bank
  // Read-only capture fields share this bank with the writable ones
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sticky_reg <= '0;
      masks_reg  <= '0;
      frame_reg  <= '0;
      pid_reg    <= '0;
      ep_reg     <= '0;
      mark_reg   <= '0;
      otg_reg    <= '0;
      power_reg  <= '0;
      phy_reg    <= '0;
    end else begin
      sticky_reg <= sticky_next;
      masks_reg  <= masks_next;
      frame_reg  <= frame_next;
      pid_reg    <= pid_next;
      ep_reg     <= ep_next;
      mark_reg   <= mark_next;
      otg_reg    <= otg_next;
      power_reg  <= power_next;
      phy_reg    <= phy_next;
    end
  end

  // Read data register: holds its word until the next read strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata   = rdata_reg;

  // Flag ports: mask byte p selects which flags drive port p
  // Bit 7 of each mask byte selects nothing
  for (genvar p = 0; p < 4; p++) begin : g_port
    assign port_any[p] = |(flags_reg & masks_reg[p*8 +: UIF_NFLAGS]);
  end
  assign flag_port_a = port_any[0];
  assign flag_port_b = port_any[1];
  assign flag_port_c = port_any[2];
  assign flag_port_d = port_any[3];

  // ==========================================================
  // Receive port endpoint with marking offset
  // Only the low four endpoint bits index the marking mask
  assign rx_port_endpoint = mark_reg[ep_reg[3:0]] ? ({1'b0, ep_reg[3:0]} | UIF_EP_MARK_OR)
                                                  : {1'b0, ep_reg[3:0]};

  // PHY control fields and plain data words
  assign auto_resume_en       = phy_reg[UIF_PHY_AUTO];
  assign phy_config_pins      = phy_reg[UIF_PHY_CONF_LO +: 3];
  assign phy_pulldown_disable = phy_reg[UIF_PHY_PD_DIS];
  assign otg_flag_mask        = otg_reg;
  assign power_word           = power_reg;
endmodule

// *** src/uif_ls_filter.sv ***
`timescale 1ns/10ps
// ==========================================================
// Linestate filter: passes a new state only after it held long enough
module uif_ls_filter
  import uif_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic [1:0]            ls_in,
  input  wire logic [3:0]            log2_len,
  output logic      [1:0]            ls_filt
);
  logic [1:0]            cand_reg;
  logic [1:0]            cand_next;
  logic [UIF_FCNT_W-1:0] cnt_reg;
  logic [UIF_FCNT_W-1:0] cnt_next;
  logic [1:0]            filt_reg;
  logic [1:0]            filt_next;
  logic [UIF_FCNT_W-1:0] limit;

  assign limit   = UIF_FCNT_W'(1) << log2_len;
  assign ls_filt = filt_reg;

  // Count how long the candidate state has stood
  always_comb begin
    cand_next = cand_reg;
    cnt_next  = cnt_reg;
    filt_next = filt_reg;
    if (ls_in != cand_reg) begin
      cand_next = ls_in;
      cnt_next  = UIF_FCNT_W'(1);
    end else if (cnt_reg < limit) begin
      cnt_next = cnt_reg + UIF_FCNT_W'(1);
    end
    if (ls_in == cand_reg && cnt_reg >= limit) begin
      filt_next = cand_reg;
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cand_reg <= UIF_LS_J;
      cnt_reg  <= '0;
      filt_reg <= UIF_LS_J;
    end else begin
      cand_reg <= cand_next;
      cnt_reg  <= cnt_next;
      filt_reg <= filt_next;
    end
  end
endmodule

// *** src/uif_pkg.sv ***
package uif_pkg;
  // ==========================================================
  // Register offsets (byte addresses on the peripheral port)
  localparam logic [7:0] UIF_ADDR_FLAGS      = 8'h1C;
  localparam logic [7:0] UIF_ADDR_STICKY     = 8'h20;
  localparam logic [7:0] UIF_ADDR_PORT_MASKS = 8'h24;
  localparam logic [7:0] UIF_ADDR_FRAME      = 8'h28;
  localparam logic [7:0] UIF_ADDR_PID        = 8'h2C;
  localparam logic [7:0] UIF_ADDR_ENDPOINT   = 8'h30;
  localparam logic [7:0] UIF_ADDR_EP_MARK    = 8'h34;
  localparam logic [7:0] UIF_ADDR_OTG_MASK   = 8'h38;
  localparam logic [7:0] UIF_ADDR_POWER      = 8'h3C;
  localparam logic [7:0] UIF_ADDR_PHY_CTRL   = 8'h40;

  // ==========================================================
  // Field widths and positions
  localparam int UIF_NFLAGS      = 7;
  localparam int UIF_FRAME_W     = 11;
  localparam int UIF_POWER_W     = 9;
  localparam int UIF_EP_VALID    = 4;
  localparam int UIF_PHY_PD_DIS  = 18;
  localparam int UIF_PHY_RST_CS  = 13;
  localparam int UIF_PHY_RES_CS  = 12;
  localparam int UIF_PHY_FILT_LO = 8;
  localparam int UIF_PHY_AUTO    = 7;
  localparam int UIF_PHY_CONF_LO = 4;

  // Signal flag bit positions
  localparam int UIF_F_RXERR  = 0;
  localparam int UIF_F_RXACT  = 1;
  localparam int UIF_F_CRC16  = 2;
  localparam int UIF_F_J      = 3;
  localparam int UIF_F_K      = 4;
  localparam int UIF_F_SE0    = 5;
  localparam int UIF_F_TOKEN  = 6;

  // Offset ORed onto marked endpoints on the receive port
  localparam logic [4:0] UIF_EP_MARK_OR = 5'h10;

  // Full-speed linestate encodings
  localparam logic [1:0] UIF_LS_SE0 = 2'h0;
  localparam logic [1:0] UIF_LS_J   = 2'h1;
  localparam logic [1:0] UIF_LS_K   = 2'h2;

  // Filter counter width: covers 2**15 cycles
  localparam int UIF_FCNT_W = 16;
endpackage

// *** testbench/uif_flag_regs_monitor.sv ***
`timescale 1ns/10ps
// ==========================================
// Port-level checker
module uif_flag_regs_monitor
  import uif_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        pid_valid,
  input wire logic [3:0]  pid_in,
  input wire logic        token_ep_valid,
  input wire logic [3:0]  token_ep,
  input wire logic        sof_valid,
  input wire logic [10:0] sof_number,
  input wire logic        resume_by_se0,
  input wire logic        resume_by_k,
  input wire logic        flag_port_a,
  input wire logic        flag_port_b,
  input wire logic        flag_port_c,
  input wire logic        flag_port_d,
  input wire logic [4:0]  rx_port_endpoint,
  input wire logic [2:0]  phy_config_pins,
  input wire logic        phy_pulldown_disable,
  input wire logic        auto_resume_en
);
  logic [3:0]  pid_reg;
  logic [4:0]  ep_reg;
  logic [10:0] frm_reg;
  wire         wr_phy = reg_wr && reg_addr == UIF_ADDR_PHY_CTRL;
  wire         rd_phy = reg_rd && !reg_wr && reg_addr == UIF_ADDR_PHY_CTRL;

  // Shadow copies of the captured fields
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pid_reg <= '0;
      ep_reg  <= '0;
      frm_reg <= '0;
    end else begin
      if (pid_valid) pid_reg <= pid_in;
      if (token_ep_valid) ep_reg <= {1'b1, token_ep};
      if (reg_wr && reg_addr == UIF_ADDR_FRAME) frm_reg <= reg_wdata[10:0];
      else if (sof_valid) frm_reg <= sof_number;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ==========================================
  // Properties
  property p_mask_zero;
    reg_wr && reg_addr == UIF_ADDR_PORT_MASKS && reg_wdata == 32'h0
      |=> !(flag_port_a | flag_port_b | flag_port_c | flag_port_d);
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("flag port high with zero mask");
  property p_phy;
    wr_phy |=> {phy_pulldown_disable, auto_resume_en, phy_config_pins} == {$past(reg_wdata[18]), $past(reg_wdata[7:4])};
  endproperty
  a_phy: assert property (p_phy) else $error("phy control pins wrong");
  property p_rst_cause;
    resume_by_se0 ##1 !reg_wr ##1 rd_phy |=> reg_rdata[13];
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset cause not set");
  property p_res_cause;
    resume_by_k ##1 !reg_wr ##1 rd_phy |=> reg_rdata[12];
  endproperty
  a_res_cause: assert property (p_res_cause) else $error("resume cause not set");
  property p_pid;
    reg_rd && reg_addr == UIF_ADDR_PID |=> reg_rdata == {28'h0, $past(pid_reg)};
  endproperty
  a_pid: assert property (p_pid) else $error("packet id read wrong");
  property p_ep;
    reg_rd && reg_addr == UIF_ADDR_ENDPOINT |=> reg_rdata == {27'h0, $past(ep_reg)};
  endproperty
  a_ep: assert property (p_ep) else $error("endpoint read wrong");
  property p_frame;
    reg_rd && reg_addr == UIF_ADDR_FRAME |=> reg_rdata == {21'h0, $past(frm_reg)};
  endproperty
  a_frame: assert property (p_frame) else $error("frame counter read wrong");
  property p_mark;
    reg_wr && reg_addr == UIF_ADDR_EP_MARK && (reg_wdata[15:0] == 16'h0 || reg_wdata[15:0] == 16'hFFFF)
      |=> rx_port_endpoint == {$past(reg_wdata[0]), ep_reg[3:0]};
  endproperty
  a_mark: assert property (p_mark) else $error("receive port endpoint wrong");

  // Main scenarios reached
  c_se0: cover property (resume_by_se0);
  c_pid: cover property (reg_rd && reg_addr == UIF_ADDR_PID && pid_reg != 4'h0);
  c_phy: cover property (wr_phy);
endmodule

bind uif_flag_regs uif_flag_regs_monitor mon (
  .mclk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pid_valid, .pid_in,
  .token_ep_valid, .token_ep, .sof_valid, .sof_number, .resume_by_se0, .resume_by_k,
  .flag_port_a, .flag_port_b, .flag_port_c, .flag_port_d, .rx_port_endpoint,
  .phy_config_pins, .phy_pulldown_disable, .auto_resume_en
);

// *** testbench/uif_phy_model.sv ***
`timescale 1ns/10ps
// ==========================================
// Transceiver: presents the requested line state
module uif_phy_model (
  input  wire logic       mclk,
  input  wire logic [1:0] ls_req,
  output logic      [1:0] phy_linestate
);
  // Pins move a little after the edge, like an unrelated source
  always @(posedge mclk) begin
    phy_linestate <= #2 ls_req;
  end
endmodule

// *** testbench/usb_interface_flag_status_regs_test.sv ***
`timescale 1ns/10ps
// ==========================================
// Self-checking bench for the flag and status registers
module usb_interface_flag_status_regs_test
  import uif_pkg::*;
;
  logic        mclk, rst_b, reg_wr, reg_rd, packet_start, token_ok, crc16_fail, rx_active, rx_error;
  logic        pid_valid, token_ep_valid, sof_valid, resume_by_se0, resume_by_k;
  logic        flag_port_a, flag_port_b, flag_port_c, flag_port_d, auto_resume_en, phy_pulldown_disable;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, otg_flag_mask, d;
  logic [3:0]  pid_in, token_ep;
  logic [10:0] sof_number;
  logic [1:0]  ls_req, phy_linestate, linestate_filt;
  logic [4:0]  rx_port_endpoint;
  logic [2:0]  phy_config_pins;
  logic [8:0]  power_word;
  int          miscompares, checks_done, n;
  logic [7:0]  ta [10] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44};
  logic [31:0] td [10] = '{32'hFFFFFFFF, 32'hA5A5A5A5, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
                           32'hFFFFFFFF, 32'hDEADBEEF, 32'hFFFFFFFF, 32'h0004CFF0, 32'hFFFFFFFF};
  logic [31:0] te [10] = '{32'h7F, 32'hA5A5A5A5, 32'h7FF, 32'h0, 32'h0,
                           32'hFFFF, 32'hDEADBEEF, 32'h1FF, 32'h00040FF0, 32'h0};

  uif_flag_regs dut (
    .mclk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .packet_start, .token_ok,
    .crc16_fail, .rx_active, .rx_error, .pid_valid, .pid_in, .token_ep_valid, .token_ep, .sof_valid,
    .sof_number, .resume_by_se0, .resume_by_k, .phy_linestate, .flag_port_a, .flag_port_b,
    .flag_port_c, .flag_port_d, .rx_port_endpoint, .linestate_filt, .auto_resume_en,
    .phy_config_pins, .phy_pulldown_disable, .otg_flag_mask, .power_word
  );
  uif_phy_model phy (.mclk, .ls_req, .phy_linestate);

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Full-word register cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {reg_wr, reg_rd, packet_start, token_ok, crc16_fail, rx_active, rx_error, pid_valid} = '0;
    {token_ep_valid, sof_valid, resume_by_se0, resume_by_k, reg_addr, reg_wdata} = '0;
    {pid_in, token_ep, sof_number} = '0;
    ls_req = UIF_LS_J;
    miscompares = 0;
    checks_done = 0;
    rst_b = 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    chk(linestate_filt, 32'h1);
    // Reset value, then write and read back every offset from 0x20 to 0x44
    for (int i = 0; i < 10; i++) begin
      rd(ta[i]);
      chk(d, 32'h0);
      wr(ta[i], td[i]);
      rd(ta[i]);
      chk(d, te[i]);
    end
    chk(otg_flag_mask, 32'hDEADBEEF);
    chk(power_word, 32'h1FF);
    chk({phy_pulldown_disable, auto_resume_en, phy_config_pins}, 32'h1F);
    // CRC flag sticky, token plain, levels follow
    wr(UIF_ADDR_STICKY, 32'h4);
    wr(UIF_ADDR_PORT_MASKS, 32'h01024004);
    @(posedge mclk);
    {crc16_fail, token_ok, rx_active, rx_error} <= 4'hF;
    @(posedge mclk);
    {crc16_fail, token_ok, rx_active} <= 3'h0;
    #1 chk({flag_port_a, flag_port_b, flag_port_c, flag_port_d}, 32'hF);
    @(posedge mclk);
    packet_start <= 1'b1;
    @(posedge mclk);
    packet_start <= 1'b0;
    rx_error     <= 1'b0;
    #1 chk({flag_port_a, flag_port_b, flag_port_c, flag_port_d}, 32'h9);
    @(posedge mclk);
    reg_wr     <= 1'b1;
    reg_addr   <= UIF_ADDR_FLAGS;
    reg_wdata  <= 32'h4;
    crc16_fail <= 1'b1;
    @(posedge mclk);
    reg_wr     <= 1'b0;
    crc16_fail <= 1'b0;
    #1 chk(flag_port_a, 32'h1);
    wr(UIF_ADDR_FLAGS, 32'h4);
    rd(UIF_ADDR_FLAGS);
    chk(d & 32'h44, 32'h0);
    wr(UIF_ADDR_PORT_MASKS, 32'h0);
    #1 chk({flag_port_a, flag_port_b, flag_port_c, flag_port_d}, 32'h0);
    // Captured fields and endpoint marking
    @(posedge mclk);
    {pid_valid, token_ep_valid, sof_valid} <= 3'h7;
    {pid_in, token_ep, sof_number} <= {4'hB, 4'h5, 11'h5A5};
    @(posedge mclk);
    {pid_valid, token_ep_valid, sof_valid} <= 3'h0;
    rd(UIF_ADDR_PID);
    chk(d, 32'hB);
    rd(UIF_ADDR_ENDPOINT);
    chk(d, 32'h15);
    rd(UIF_ADDR_FRAME);
    chk(d, 32'h5A5);
    wr(UIF_ADDR_EP_MARK, 32'h20);
    #1 chk(rx_port_endpoint, 32'h15);
    wr(UIF_ADDR_EP_MARK, 32'hFFDF);
    #1 chk(rx_port_endpoint, 32'h5);
    // Cause bits hold until written to zero
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      {resume_by_se0, resume_by_k} <= (k == 0) ? 2'h2 : 2'h1;
      @(posedge mclk);
      {resume_by_se0, resume_by_k} <= 2'h0;
      rd(UIF_ADDR_PHY_CTRL);
      chk(d & 32'h3000, (k == 0) ? 32'h2000 : 32'h3000);
    end
    wr(UIF_ADDR_PHY_CTRL, 32'h200);
    rd(UIF_ADDR_PHY_CTRL);
    chk(d, 32'h200);
    // Filter length 4: short glitch dropped, held change passes
    @(posedge mclk);
    ls_req <= UIF_LS_K;
    repeat (2) @(posedge mclk);
    ls_req <= UIF_LS_J;
    repeat (12) @(posedge mclk);
    chk(linestate_filt, 32'h1);
    ls_req <= UIF_LS_K;
    n = 0;
    while (linestate_filt !== UIF_LS_K && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 40) begin
      miscompares++;
    end
    chk(n >= 6 && n <= 11, 32'h1);
    // Mid-run reset: power word, config pins, receive endpoint, linestate and PHY control return to reset values
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    #1 chk({power_word, phy_config_pins, rx_port_endpoint, linestate_filt}, {17'h0, UIF_LS_J});
    rd(UIF_ADDR_PHY_CTRL);
    chk(d, 32'h0);
    give_verdict();
  end
endmodule
